// ==== verilog/svm_pkg.sv ====
// Constants, register map and carrier types of the supply voltage monitor
package svm_pkg;
  localparam int CLK_PERIOD_NS  = 25;
  // Deglitch least time, rounded up to whole cycles
  localparam int DEG_TIME_NS    = 8000;
  localparam int DEG_CYCLES     = (DEG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Short-to-ground times, nominal values
  localparam int IO_STG_TIME_NS   = 4000000;
  localparam int RAIL_STG_TIME_NS = 3000000;
  localparam int IO_STG_CYCLES    = IO_STG_TIME_NS / CLK_PERIOD_NS;
  localparam int RAIL_STG_CYCLES  = RAIL_STG_TIME_NS / CLK_PERIOD_NS;
  localparam int DEG_W  = 9;
  localparam int STG_W  = 18;
  localparam int NRAIL  = 5;
  localparam int NCH    = 6;
  localparam int NEVT   = 23;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR  = 8'h04;
  localparam logic [7:0] OFS_IRQEN  = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_STATE  = 8'h10;
  // Event bit positions in status, clear and enable
  localparam int EV_IO_UV     = 0;
  localparam int EV_IO_OV     = 1;
  localparam int EV_IO_STG    = 2;
  localparam int EV_BAT_UV    = 3;
  localparam int EV_RAIL_UV   = 4;
  localparam int EV_RAIL_OV   = 9;
  localparam int EV_RAIL_STG  = 14;
  localparam int EV_REF_WARN  = 19;
  localparam int EV_REF_FAULT = 21;
  // Control bits: 0 main step-down, 1 post step-down, 2 post step-up, 3/4 external rails
  localparam int CTRL_EXT1 = 3;
  localparam int CTRL_EXT2 = 4;
  localparam logic [NEVT-1:0]  IRQEN_RESET = 23'h180000;
  localparam logic [NRAIL-1:0] CTRL_RESET  = 5'h00;

  typedef struct packed {
    logic             ioUv;
    logic             ioOv;
    logic             batUv;
    logic [NRAIL-1:0] railUv;
    logic [NRAIL-1:0] railOv;
    logic [1:0]       railDuv;
    logic [1:0]       refWarn;
    logic [1:0]       refFault;
  } svm_cmp_t;
endpackage

// ==== verilog/svm_monitor.sv ====
// Supply voltage monitor: comparator qualification, events, reset output, APB registers
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module svm_monitor
  import svm_pkg::*;
#(
  parameter int IO_STG_CYC   = IO_STG_CYCLES,
  parameter int RAIL_STG_CYC = RAIL_STG_CYCLES
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Comparator outputs, asynchronous
  input  wire svm_cmp_t         cmpIn,
  // Supply control
  output logic      [NRAIL-1:0] railEnable,
  output logic                  reset_out_n,
  output logic                  hardReset,
  output logic                  faultState,
  output logic                  irq
);
  localparam logic [DEG_W-1:0] DEG_LIM = DEG_W'(DEG_CYCLES);

  svm_cmp_t         cmpMeta;
  svm_cmp_t         cmpSync;
  logic [NCH-1:0]   uvIn;
  logic [NCH-1:0]   ovIn;
  logic [NCH-1:0]   duvIn;
  logic [NCH-1:0]   uvEvt;
  logic [NCH-1:0]   ovEvt;
  logic [NCH-1:0]   stgEvt;
  logic [NCH-1:0]   uvQual;
  logic [NCH-1:0]   ovQual;
  logic [NEVT-1:0]  evt;
  logic [NEVT-1:0]  status;
  logic [NEVT-1:0]  next_status;
  logic [NEVT-1:0]  irqEn;
  logic [NEVT-1:0]  next_irqEn;
  logic [NRAIL-1:0] ctrl;
  logic [NRAIL-1:0] next_ctrl;
  logic             next_faultState;
  logic             next_resetOutN;
  logic             next_hardReset;
  logic [31:0]      next_prdata;
  logic             rdHit;
  logic             wrAcc;

  // Two-flop synchroniser for every comparator
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmpMeta <= '0;
      cmpSync <= '0;
    end
    else
    begin
      cmpMeta <= cmpIn;
      cmpSync <= cmpMeta;
    end
  end

  // Channel 0 is the io supply, channels 1 to 5 follow the control bits
  assign uvIn  = {cmpSync.railUv & ctrl, cmpSync.ioUv};
  assign ovIn  = {cmpSync.railOv & ctrl, cmpSync.ioOv};
  assign duvIn = {3'b000, cmpSync.railDuv & ctrl[1:0], 1'b0};

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      localparam logic [STG_W-1:0] STG_LIM = (g == 0) ? STG_W'(IO_STG_CYC)
                                                      : STG_W'(RAIL_STG_CYC);
      logic [DEG_W-1:0] uvDeg;
      logic [DEG_W-1:0] ovDeg;
      logic [DEG_W-1:0] duvDeg;
      logic [STG_W-1:0] stgCnt;
      logic [DEG_W-1:0] next_uvDeg;
      logic [DEG_W-1:0] next_ovDeg;
      logic [DEG_W-1:0] next_duvDeg;
      logic [STG_W-1:0] next_stgCnt;

      // Saturating timers that restart whenever the condition clears
      always_comb
      begin
        next_uvDeg  = !uvIn[g] ? '0 : (uvDeg == DEG_LIM) ? uvDeg : uvDeg + 1'b1;
        next_ovDeg  = !ovIn[g] ? '0 : (ovDeg == DEG_LIM) ? ovDeg : ovDeg + 1'b1;
        next_duvDeg = !duvIn[g] ? '0 : (duvDeg == DEG_LIM) ? duvDeg : duvDeg + 1'b1;
        next_stgCnt = !uvIn[g] ? '0 : (stgCnt == STG_LIM) ? stgCnt : stgCnt + 1'b1;
      end

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          uvDeg  <= '0;
          ovDeg  <= '0;
          duvDeg <= '0;
          stgCnt <= '0;
        end
        else
        begin
          uvDeg  <= next_uvDeg;
          ovDeg  <= next_ovDeg;
          duvDeg <= next_duvDeg;
          stgCnt <= next_stgCnt;
        end
      end

      assign uvEvt[g]  = uvIn[g] && (uvDeg == DEG_LIM - 1'b1);
      assign ovEvt[g]  = ovIn[g] && (ovDeg == DEG_LIM - 1'b1);
      assign uvQual[g] = (uvDeg == DEG_LIM);
      assign ovQual[g] = (ovDeg == DEG_LIM);
      assign stgEvt[g] = (uvIn[g] && (stgCnt == STG_LIM - 1'b1))
                       || (duvIn[g] && (duvDeg == DEG_LIM - 1'b1));
    end
  endgenerate

  // Event vector
  always_comb
  begin
    evt = '0;
    evt[EV_IO_UV]                = uvEvt[0] | stgEvt[0];
    evt[EV_IO_OV]                = ovEvt[0];
    evt[EV_IO_STG]               = stgEvt[0];
    evt[EV_BAT_UV]               = cmpSync.batUv;
    evt[EV_RAIL_UV +: NRAIL]     = uvEvt[NCH-1:1];
    evt[EV_RAIL_OV +: NRAIL]     = ovEvt[NCH-1:1];
    evt[EV_RAIL_STG +: NRAIL]    = stgEvt[NCH-1:1];
    evt[EV_REF_WARN +: 2]        = cmpSync.refWarn;
    evt[EV_REF_FAULT +: 2]       = cmpSync.refFault;
  end

  assign rdHit = (paddr == OFS_STATUS) || (paddr == OFS_CLEAR) || (paddr == OFS_IRQEN)
              || (paddr == OFS_CTRL) || (paddr == OFS_STATE);
  assign wrAcc = psel && penable && pwrite && rdHit;

  // Registers, protection and reset output
  always_comb
  begin
    next_status = status;
    if (wrAcc && paddr == OFS_CLEAR)
    begin
      next_status = status & ~pwdata[NEVT-1:0];
    end
    next_status = next_status | evt;
    next_irqEn = irqEn;
    if (wrAcc && paddr == OFS_IRQEN)
    begin
      next_irqEn = pwdata[NEVT-1:0];
    end
    next_ctrl = ctrl;
    if (wrAcc && paddr == OFS_CTRL && !faultState)
    begin
      next_ctrl = pwdata[NRAIL-1:0];
    end
    if (ovEvt[CTRL_EXT1 + 1] || stgEvt[CTRL_EXT1 + 1])
    begin
      next_ctrl[CTRL_EXT1] = 1'b0;
    end
    if (ovEvt[CTRL_EXT2 + 1] || stgEvt[CTRL_EXT2 + 1])
    begin
      next_ctrl[CTRL_EXT2] = 1'b0;
    end
    next_faultState = faultState | (|cmpSync.refFault);
    if (next_faultState)
    begin
      next_ctrl = '0;
    end
    next_hardReset = stgEvt[0];
    next_resetOutN = !(uvQual[0] || ovQual[0] || stgEvt[0]);
    next_prdata = prdata;
    if (psel && !penable)
    begin
      case (paddr)
        OFS_STATUS: next_prdata = 32'(status);
        OFS_IRQEN:  next_prdata = 32'(irqEn);
        OFS_CTRL:   next_prdata = 32'(ctrl);
        OFS_STATE:  next_prdata = 32'({ovQual, uvQual, faultState, reset_out_n});
        default:    next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status      <= '0;
      irqEn       <= IRQEN_RESET;
      ctrl        <= CTRL_RESET;
      faultState  <= 1'b0;
      hardReset   <= 1'b0;
      reset_out_n <= 1'b0;
      prdata      <= 32'h00000000;
    end
    else
    begin
      status      <= next_status;
      irqEn       <= next_irqEn;
      ctrl        <= next_ctrl;
      faultState  <= next_faultState;
      hardReset   <= next_hardReset;
      reset_out_n <= next_resetOutN;
      prdata      <= next_prdata;
    end
  end

  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !rdHit;
  assign railEnable = ctrl;
  assign irq        = |(status & irqEn);

  property p_ioResetLow;
    @(posedge clk) disable iff (!reset_n)
    (uvQual[0] || ovQual[0]) |=> !reset_out_n;
  endproperty
  a_ioResetLow: assert property (p_ioResetLow) else $error("reset output not low");

  property p_ioResetHigh;
    @(posedge clk) disable iff (!reset_n)
    (!uvIn[0] && !ovIn[0]) [*2] |=> reset_out_n;
  endproperty
  a_ioResetHigh: assert property (p_ioResetHigh) else $error("reset output not released");

  property p_ioStgTime;
    @(posedge clk) disable iff (!reset_n)
    stgEvt[0] |-> g_ch[0].stgCnt == STG_W'(IO_STG_CYC - 1) || !uvIn[0];
  endproperty
  a_ioStgTime: assert property (p_ioStgTime) else $error("io short event early");

  property p_ioStgEffect;
    @(posedge clk) disable iff (!reset_n)
    stgEvt[0] |=> hardReset && status[EV_IO_UV] && status[EV_IO_STG];
  endproperty
  a_ioStgEffect: assert property (p_ioStgEffect) else $error("io short not acted on");

  property p_batFlag;
    @(posedge clk) disable iff (!reset_n)
    cmpSync.batUv |=> status[EV_BAT_UV];
  endproperty
  a_batFlag: assert property (p_batFlag) else $error("battery flag missing");

  property p_deglitch;
    @(posedge clk) disable iff (!reset_n)
    $rose(uvIn[1]) |-> !uvEvt[1] [*8];
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("glitch taken as event");

  property p_railStg;
    @(posedge clk) disable iff (!reset_n)
    (uvIn[2] && g_ch[2].stgCnt == STG_W'(RAIL_STG_CYC - 1)) |=> status[EV_RAIL_STG + 1];
  endproperty
  a_railStg: assert property (p_railStg) else $error("rail short flag missing");

  property p_deepUv;
    @(posedge clk) disable iff (!reset_n)
    (duvIn[1] && g_ch[1].duvDeg == DEG_LIM - 1'b1) |=> status[EV_RAIL_STG];
  endproperty
  a_deepUv: assert property (p_deepUv) else $error("deep undervoltage missed");

  property p_monGate;
    @(posedge clk) disable iff (!reset_n)
    !ctrl[0] |-> !uvIn[1] && !ovIn[1] && !uvEvt[1];
  endproperty
  a_monGate: assert property (p_monGate) else $error("disabled rail monitored");

  property p_extGate;
    @(posedge clk) disable iff (!reset_n)
    !railEnable[CTRL_EXT1] |=> g_ch[CTRL_EXT1 + 1].uvDeg == '0;
  endproperty
  a_extGate: assert property (p_extGate) else $error("external rail monitored while off");

  property p_extShut;
    @(posedge clk) disable iff (!reset_n)
    (ovEvt[CTRL_EXT2 + 1] || stgEvt[CTRL_EXT2 + 1]) |=> !railEnable[CTRL_EXT2];
  endproperty
  a_extShut: assert property (p_extShut) else $error("external rail not shut down");

  property p_warnIrq;
    @(posedge clk) disable iff (!reset_n)
    (cmpSync.refWarn[0] && irqEn[EV_REF_WARN]) |=> irq;
  endproperty
  a_warnIrq: assert property (p_warnIrq) else $error("warning without interrupt");

  property p_fault;
    @(posedge clk) disable iff (!reset_n)
    |cmpSync.refFault |=> faultState && railEnable == '0 ##1 faultState;
  endproperty
  a_fault: assert property (p_fault) else $error("fault state not entered");

  property p_timerRestart;
    @(posedge clk) disable iff (!reset_n)
    !ovIn[3] |=> g_ch[3].ovDeg == '0;
  endproperty
  a_timerRestart: assert property (p_timerRestart) else $error("timer not restarted");

  property p_convUv;
    @(posedge clk) disable iff (!reset_n)
    (uvIn[1] && g_ch[1].uvDeg == DEG_LIM - 1'b1) |=> status[EV_RAIL_UV];
  endproperty
  a_convUv: assert property (p_convUv) else $error("converter undervoltage flag missing");

  property p_extOv;
    @(posedge clk) disable iff (!reset_n)
    (ovIn[CTRL_EXT1 + 1] && g_ch[CTRL_EXT1 + 1].ovDeg == DEG_LIM - 1'b1)
      |=> status[EV_RAIL_OV + CTRL_EXT1];
  endproperty
  a_extOv: assert property (p_extOv) else $error("external overvoltage flag missing");

  property p_extStg;
    @(posedge clk) disable iff (!reset_n)
    (uvIn[CTRL_EXT2 + 1] && g_ch[CTRL_EXT2 + 1].stgCnt == STG_W'(RAIL_STG_CYC - 1))
      |=> status[EV_RAIL_STG + CTRL_EXT2];
  endproperty
  a_extStg: assert property (p_extStg) else $error("external short flag missing");

  property p_hardPulse;
    @(posedge clk) disable iff (!reset_n)
    hardReset |=> !hardReset;
  endproperty
  a_hardPulse: assert property (p_hardPulse) else $error("hard reset longer than a pulse");

  property p_setWins;
    @(posedge clk) disable iff (!reset_n)
    (wrAcc && paddr == OFS_CLEAR && evt[EV_BAT_UV]) |=> status[EV_BAT_UV];
  endproperty
  a_setWins: assert property (p_setWins) else $error("clear beat a battery event");

  property p_ctrlLocked;
    @(posedge clk) disable iff (!reset_n)
    faultState |=> railEnable == '0;
  endproperty
  a_ctrlLocked: assert property (p_ctrlLocked) else $error("rail enabled in fault state");

  property p_faultSticky;
    @(posedge clk) disable iff (!reset_n)
    faultState |=> faultState;
  endproperty
  a_faultSticky: assert property (p_faultSticky) else $error("fault state left");

  property p_warnLevel;
    @(posedge clk) disable iff (!reset_n)
    (status[EV_REF_WARN] && irqEn[EV_REF_WARN]) |-> irq;
  endproperty
  a_warnLevel: assert property (p_warnLevel) else $error("warning flag without interrupt");

  c_ioStg:   cover property (@(posedge clk) disable iff (!reset_n) stgEvt[0]);
  c_extShut: cover property (@(posedge clk) disable iff (!reset_n) ovEvt[4] ##1 !railEnable[3]);
  c_fault:   cover property (@(posedge clk) disable iff (!reset_n) $rose(faultState));
  c_irq:     cover property (@(posedge clk) disable iff (!reset_n) $rose(irq));
  c_deepUv:  cover property (@(posedge clk) disable iff (!reset_n) stgEvt[2]);
endmodule

// ==== sim/svm_rail_model.sv ====
// Model of the supervised rails and reference checks feeding the monitor
`timescale 1ns/1ps
module svm_rail_model
  import svm_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Requested conditions and rail enables
  input  wire svm_cmp_t         faultReq,
  input  wire logic [NRAIL-1:0] railEnable,
  // Comparator levels
  output svm_cmp_t              cmpIn
);
  svm_cmp_t level;

  // A switched-off external rail collapses and reads as undervoltage
  always_comb
  begin
    level = faultReq;
    level.railUv[CTRL_EXT2:CTRL_EXT1] = faultReq.railUv[CTRL_EXT2:CTRL_EXT1]
                                      | ~railEnable[CTRL_EXT2:CTRL_EXT1];
  end

  always @(posedge clk)
    cmpIn <= level;
endmodule

// ==== sim/svm_monitor_bench.sv ====
// Self-checking bench for the supply voltage monitor
`timescale 1ns/1ps
module svm_monitor_bench;
  import svm_pkg::*;
  logic             clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             lastErr;
  svm_cmp_t         req = '0;
  svm_cmp_t         cmpIn;
  svm_cmp_t         c;
  logic [NRAIL-1:0] railEnable;
  logic             reset_out_n;
  logic             hardReset;
  logic             faultState;
  logic             irq;
  logic [31:0]      r;
  int               errTotal = 0;
  int               samplesChecked = 0;
  int               hrCount = 0;

  always #12.5 clk = ~clk;

  svm_monitor #(.IO_STG_CYC(500), .RAIL_STG_CYC(400)) u_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmpIn(cmpIn), .railEnable(railEnable), .reset_out_n(reset_out_n),
    .hardReset(hardReset), .faultState(faultState), .irq(irq));

  svm_rail_model u_rails (.clk(clk), .faultReq(req), .railEnable(railEnable), .cmpIn(cmpIn));

  always @(posedge clk)
    if (hardReset === 1'b1)
      hrCount++;

  task automatic results();
    $display("checks=%0d errors=%0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
    begin
      errTotal++;
      results();
    end
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask

  function automatic logic [31:0] bt(input int i);
    return 32'h1 << i;
  endfunction

  // Apply a condition for n cycles, then let it settle
  task automatic hold(input svm_cmp_t v, input int n);
    req <= v;
    repeat (n) @(posedge clk);
    req <= '0;
    repeat (8) @(posedge clk);
  endtask

  // Compare sticky status, then clear it
  task automatic stat(input logic [31:0] exp);
    rdchk(OFS_STATUS, exp);
    apb(1'b1, OFS_CLEAR, 32'h007FFFFF);
  endtask

  initial
  begin
    #500000;
    errTotal++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(OFS_STATUS, 32'h0);
    rdchk(OFS_IRQEN, 32'(IRQEN_RESET));
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_STATE, 32'h1);
    rdchk(8'h14, 32'h0);
    check(32'(lastErr), 32'h1);
    check(32'(pready), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1F);
    check(32'(railEnable), 32'h1F);
    c = '0;
    c.railUv[0] = 1'b1;
    hold(c, 300);
    stat(32'h0);
    req <= c;
    repeat (200) @(posedge clk);
    req <= '0;
    @(posedge clk);
    hold(c, 200);
    stat(32'h0);
    hold(c, 340);
    stat(bt(EV_RAIL_UV));
    c = '0;
    c.railUv[2] = 1'b1;
    hold(c, 450);
    stat(bt(EV_RAIL_UV + 2) | bt(EV_RAIL_STG + 2));
    apb(1'b1, OFS_CTRL, 32'h1B);
    hold(c, 340);
    stat(32'h0);
    apb(1'b1, OFS_CTRL, 32'h1F);
    c = '0;
    c.railDuv[1] = 1'b1;
    hold(c, 340);
    stat(bt(EV_RAIL_STG + 1));
    c = '0;
    c.railOv[3] = 1'b1;
    hold(c, 340);
    stat(bt(EV_RAIL_OV + 3));
    check(32'(railEnable), 32'h17);
    hold(c, 340);
    stat(32'h0);
    c = '0;
    c.railUv[4] = 1'b1;
    hold(c, 450);
    stat(bt(EV_RAIL_UV + 4) | bt(EV_RAIL_STG + 4));
    check(32'(railEnable), 32'h07);
    for (int k = 0; k < 2; k++)
    begin
      c = '0;
      c.ioUv = (k == 0);
      c.ioOv = (k == 1);
      req <= c;
      repeat (340) @(posedge clk);
      check(32'(reset_out_n), 32'h0);
      rdchk(OFS_STATE, (k == 0) ? 32'h00000004 : 32'h00000100);
      req <= '0;
      repeat (8) @(posedge clk);
      check(32'(reset_out_n), 32'h1);
      stat(bt(k));
    end
    c = '0;
    c.ioUv = 1'b1;
    hrCount = 0;
    hold(c, 540);
    stat(bt(EV_IO_UV) | bt(EV_IO_STG));
    check(32'(hrCount), 32'h1);
    c = '0;
    c.batUv = 1'b1;
    req <= c;
    repeat (8) @(posedge clk);
    stat(bt(EV_BAT_UV));
    hold('0, 8);
    stat(bt(EV_BAT_UV));
    c = '0;
    c.refWarn[0] = 1'b1;
    hold(c, 10);
    check(32'(irq), 32'h1);
    stat(bt(EV_REF_WARN));
    check(32'(irq), 32'h0);
    apb(1'b1, OFS_IRQEN, 32'h0);
    c = '0;
    c.refWarn[1] = 1'b1;
    hold(c, 10);
    check(32'(irq), 32'h0);
    stat(bt(EV_REF_WARN + 1));
    c = '0;
    c.refFault[1] = 1'b1;
    hold(c, 10);
    check(32'(faultState), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1F);
    check(32'(railEnable), 32'h0);
    stat(bt(EV_REF_FAULT + 1));
    results();
  end
endmodule
